/* File: hw/dis_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module dis_fifo #(
  parameter int WIDTH = 23, // word width
  parameter int DEPTH = 16 // word count, power of two
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid, // word available
  input wire logic out_ready, // sink takes word
  output logic [WIDTH-1:0] out_data // word out
);
  localparam int AW = $clog2(DEPTH); // pointer width
  logic [WIDTH-1:0] mem_r [DEPTH]; // storage
  logic [AW:0] wp_r; // write pointer, extra wrap bit
  logic [AW:0] rp_r; // read pointer, extra wrap bit
  // ************************************************************
  // flags
  // ************************************************************
  assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign out_data = mem_r[rp_r[AW-1:0]];
  // write side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
    end else if (in_valid && in_ready) begin
      wp_r <= wp_r + 1'b1;
    end
  end
  // storage array, no reset needed
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
  // read side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_r <= '0;
    end else if (out_valid && out_ready) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: hw/dis_i2c_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module dis_i2c_slave
  import dis_pkg::*;
#(
  parameter int SWITCH_CYC = dis_pkg::DIS_SWITCH_CYC, // hold-off count
  parameter int FIFO_DEPTH = dis_pkg::DIS_FIFO_DEPTH // write buffer depth
) (
  input wire logic clk, // 10 mhz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive value, always 0
  output logic sda_oe_n, // low while pulling data low
  input wire logic select_pin_low, // strap for address bit 1
  input wire logic select_pin_high, // strap for address bit 2
  input wire logic supply_trip_threshold, // high while supply below trip
  output logic mem_wr_valid, // memory write offered
  input wire logic mem_wr_ready, // memory takes write
  output logic [dis_pkg::DIS_MEM_AW-1:0] mem_wr_addr, // memory write address
  output logic [7:0] mem_wr_data, // memory write byte
  output logic [dis_pkg::DIS_MEM_AW-1:0] mem_rd_addr, // memory read address, current pointer
  input wire logic [7:0] mem_rd_data, // memory byte at read address
  output logic reg_wr_stb, // register write pulse
  output logic [7:0] reg_addr, // register pointer
  output logic [7:0] reg_wr_data, // register write byte
  input wire logic [7:0] reg_rd_data, // register byte at pointer
  output logic busy // addressed transaction in progress
);
  localparam int FW = dis_pkg::DIS_MEM_AW + 8; // fifo word width
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] scl_s_r; // scl two-stage
  logic [1:0] sda_s_r; // sda two-stage
  logic [1:0] trip_s_r; // trip two-stage
  logic scl_d_r; // delayed synced scl
  logic sda_d_r; // delayed synced sda
  logic [1:0] sel_s0_r; // select straps, first stage
  logic [1:0] sel_s1_r; // select straps, second stage
  // capture all async inputs, then keep previous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      trip_s_r <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sel_s0_r <= 2'h0;
      sel_s1_r <= 2'h0;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      trip_s_r <= {trip_s_r[0], supply_trip_threshold};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
      sel_s0_r <= {select_pin_high, select_pin_low};
      sel_s1_r <= sel_s0_r;
    end
  end
  wire scl_c = scl_s_r[1]; // clean scl
  wire sda_c = sda_s_r[1]; // clean sda
  wire scl_rise = scl_c && !scl_d_r; // data sampling edge
  wire scl_fall = !scl_c && scl_d_r; // data launching edge
  wire start_det = scl_c && scl_d_r && !sda_c && sda_d_r;
  wire stop_det = scl_c && scl_d_r && sda_c && !sda_d_r;
  wire trip = trip_s_r[1];
  // ************************************************************
  // protocol state
  // ************************************************************
  dis_state_type state_r; // byte phase
  logic [3:0] bit_r; // bits of current byte, 8 and 9 mean ack slot
  logic [7:0] sh_r; // shift register
  logic is_reg_r; // register target active
  logic ack_now_r; // ack decision held for ninth clock
  logic addr_rd_r; // address byte requested read
  logic ack_slot_r; // ninth clock in progress
  logic drive_r; // pulling sda low
  logic [dis_pkg::DIS_MEM_AW-1:0] mem_ptr_r; // memory pointer
  logic [7:0] reg_ptr_r; // register pointer
  logic [6:0] ptr_hi_r; // pending high address byte
  logic [$clog2(SWITCH_CYC+1)-1:0] hold_r; // switch hold-off counter
  logic fifo_ready; // write buffer room
  logic fifo_in_valid_r; // byte offered to buffer
  logic [FW-1:0] fifo_in_r; // address and byte to buffer
  // abort condition shared by the state, driver, pointer and write processes
  wire abort = start_det || stop_det || trip;
  wire byte_done = scl_rise && (bit_r == 4'h7); // eighth bit sampled
  wire [7:0] rx_byte = {sh_r[6:0], sda_c};
  wire sel_ok = (rx_byte[DIS_SEL_MSB:1] == sel_s1_r);
  wire mem_hit = (rx_byte[DIS_ID_MSB:4] == DIS_MEM_ID) && (hold_r == '0);
  wire reg_hit = (rx_byte[DIS_ID_MSB:4] == DIS_REG_ID);
  // ack value decided at eighth bit, per phase
  function automatic logic want_ack(input dis_state_type st, input logic [7:0] b, input logic sel,
                                    input logic mh, input logic rh, input logic fr);
    case (st)
      DIS_ADDR: want_ack = sel && (mh || rh);
      DIS_PTR_HI: want_ack = 1'b1;
      DIS_PTR_LO: want_ack = (b <= DIS_REG_MAX) || mh; // mh is mem_hit of the pointer byte; ack_now uses ptr_lo_ok in this phase
      DIS_WDATA: want_ack = fr;
      default: want_ack = 1'b0;
    endcase
  endfunction
  wire ptr_lo_ok = is_reg_r ? (rx_byte <= DIS_REG_MAX) : 1'b1;
  wire ack_now = (state_r == DIS_PTR_LO) ? ptr_lo_ok
               : want_ack(state_r, rx_byte, sel_ok, mem_hit, reg_hit, fifo_ready);
  // ************************************************************
  // bit counter and state machine
  // ************************************************************
  // counts bits, steps phases, aborts on start, stop, trip or nack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= DIS_IDLE;
      bit_r <= 4'h0;
      ack_slot_r <= 1'b0;
      is_reg_r <= 1'b0;
    end else if (start_det && !trip) begin
      state_r <= DIS_ADDR;
      bit_r <= 4'h0;
      ack_slot_r <= 1'b0;
      is_reg_r <= 1'b0; // stale target must not re-arm the hold-off
    end else if (abort) begin
      state_r <= DIS_IDLE;
      bit_r <= 4'h0;
      ack_slot_r <= 1'b0;
    end else if (state_r != DIS_IDLE) begin
      if (scl_rise && ack_slot_r) begin
        // ninth clock high: master ack on read data bytes
        if (state_r == DIS_RDATA && !addr_rd_r && sda_c) begin
          state_r <= DIS_IDLE;
        end
      end else if (scl_fall && ack_slot_r && bit_r == 4'h8) begin
        bit_r <= 4'h9; // ninth clock low phase begins
      end else if (scl_fall && ack_slot_r) begin
        ack_slot_r <= 1'b0;
        bit_r <= 4'h0;
      end else if (byte_done) begin
        ack_slot_r <= 1'b1;
        bit_r <= 4'h8;
        case (state_r)
          DIS_ADDR: begin
            if (!(sel_ok && (mem_hit || reg_hit))) begin
              state_r <= DIS_IDLE;
            end else begin
              is_reg_r <= reg_hit && !mem_hit;
              if (rx_byte[DIS_RW_BIT]) begin
                state_r <= DIS_RDATA;
              end else begin
                state_r <= reg_hit && !mem_hit ? DIS_PTR_LO : DIS_PTR_HI;
              end
            end
          end
          DIS_PTR_HI: state_r <= DIS_PTR_LO;
          DIS_PTR_LO: state_r <= ptr_lo_ok ? DIS_WDATA : DIS_IDLE;
          DIS_WDATA: state_r <= fifo_ready ? DIS_WDATA : DIS_IDLE;
          DIS_RDATA: state_r <= DIS_RDATA;
          default: state_r <= DIS_IDLE;
        endcase
      end else if (scl_rise) begin
        bit_r <= bit_r + 4'h1;
      end
    end
  end
  // ************************************************************
  // shift register
  // ************************************************************
  // receive msb first, or load and shift transmit byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= 8'h00;
    end else if (state_r == DIS_RDATA && scl_fall && (ack_slot_r ? (bit_r == 4'h9) : (bit_r != 4'h0))) begin
      if (ack_slot_r) begin
        sh_r <= is_reg_r ? reg_rd_data : mem_rd_data;
      end else begin
        sh_r <= {sh_r[6:0], 1'b1};
      end
    end else if (scl_rise && state_r != DIS_RDATA && !ack_slot_r) begin
      sh_r <= rx_byte;
    end
  end
  // ************************************************************
  // sda driver
  // ************************************************************
  // changes only after scl falls, releases on abort
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= 1'b0;
    end else if (abort) begin
      drive_r <= 1'b0;
    end else if (scl_fall) begin
      if (ack_slot_r && bit_r == 4'h8) begin
        drive_r <= ack_now_r;
      end else if (ack_slot_r && state_r == DIS_RDATA) begin
        drive_r <= !(is_reg_r ? reg_rd_data[7] : mem_rd_data[7]);
      end else if (state_r == DIS_RDATA && !ack_slot_r && bit_r != 4'h0) begin
        drive_r <= !sh_r[6];
      end else begin
        drive_r <= 1'b0; // release at the end of the ack slot and for received bits
      end
    end
  end
  // latch ack decision at the eighth rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_now_r <= 1'b0;
      addr_rd_r <= 1'b0;
    end else if (byte_done && !ack_slot_r) begin
      ack_now_r <= ack_now && !(state_r == DIS_RDATA);
      addr_rd_r <= (state_r == DIS_ADDR) && rx_byte[DIS_RW_BIT];
    end
  end
  // ************************************************************
  // pointers
  // ************************************************************
  // separate pointers, load and increment with wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ptr_r <= DIS_MEM_PTR_RST;
      reg_ptr_r <= DIS_REG_PTR_RST;
      ptr_hi_r <= 7'h00;
    end else if (byte_done && !ack_slot_r && !abort) begin
      case (state_r)
        DIS_PTR_HI: ptr_hi_r <= rx_byte[6:0];
        DIS_PTR_LO: begin
          if (is_reg_r) begin
            if (ptr_lo_ok) reg_ptr_r <= rx_byte;
          end else begin
            mem_ptr_r <= {ptr_hi_r, rx_byte};
          end
        end
        DIS_WDATA, DIS_RDATA: begin
          if (is_reg_r) begin
            reg_ptr_r <= (reg_ptr_r == DIS_REG_MAX) ? 8'h00 : reg_ptr_r + 8'h01;
          end else begin
            mem_ptr_r <= mem_ptr_r + 1'b1; // natural wrap to zero
          end
        end
        default: ;
      endcase
    end
  end
  // ************************************************************
  // memory write path through buffer
  // ************************************************************
  // queue address and byte once eighth bit is in
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_in_valid_r <= 1'b0;
      fifo_in_r <= '0;
    end else begin
      fifo_in_valid_r <= byte_done && !ack_slot_r && !abort && state_r == DIS_WDATA
                         && !is_reg_r && fifo_ready;
      fifo_in_r <= {mem_ptr_r, rx_byte};
    end
  end
  logic fifo_out_valid; // buffer has word
  logic [FW-1:0] fifo_out; // buffer head
  dis_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid_r),
    .in_ready(fifo_ready),
    .in_data(fifo_in_r),
    .out_valid(fifo_out_valid),
    .out_ready(mem_wr_ready || !mem_wr_valid),
    .out_data(fifo_out)
  );
  // output stage holds the head until memory accepts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= 8'h00;
    end else if (mem_wr_ready || !mem_wr_valid) begin
      mem_wr_valid <= fifo_out_valid;
      mem_wr_addr <= fifo_out[FW-1:8];
      mem_wr_data <= fifo_out[7:0];
    end
  end
  // ************************************************************
  // register strobe, hold-off timer, outputs
  // ************************************************************
  // register writes, hold-off after register use, status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_stb <= 1'b0;
      reg_wr_data <= 8'h00;
      reg_addr <= DIS_REG_PTR_RST;
      mem_rd_addr <= DIS_MEM_PTR_RST;
      hold_r <= '0;
      busy <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      reg_wr_stb <= byte_done && !ack_slot_r && !abort && state_r == DIS_WDATA && is_reg_r;
      reg_wr_data <= rx_byte;
      reg_addr <= reg_ptr_r;
      mem_rd_addr <= mem_ptr_r;
      busy <= state_r != DIS_IDLE && state_r != DIS_ADDR;
      sda_o <= 1'b0;
      sda_oe_n <= !drive_r;
      if (is_reg_r && state_r != DIS_IDLE) begin
        hold_r <= ($bits(hold_r))'(SWITCH_CYC);
      end else if (hold_r != '0) begin
        hold_r <= hold_r - 1'b1;
      end
    end
  end
  // ************************************************************
  // checks
  // ************************************************************
  no_reg_mem_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_reg_r |-> ##1 !fifo_in_valid_r) else $error("memory written during register access");
  start_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    (start_det && !trip) |=> state_r == DIS_ADDR && bit_r == 4'h0) else $error("start not restarting");
  stop_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    (stop_det && !start_det) |=> state_r == DIS_IDLE && !drive_r) else $error("stop not aborting");
  trip_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    trip |=> state_r == DIS_IDLE && !drive_r) else $error("trip not aborting");
  sda_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    (scl_c && scl_d_r && !abort) |=> $stable(drive_r)) else $error("sda moved while scl high");
  reg_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_ptr_r <= DIS_REG_MAX) else $error("register pointer out of range");
  mem_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (byte_done && !ack_slot_r && !abort && !is_reg_r && state_r == DIS_RDATA)
    |=> mem_ptr_r == $past(mem_ptr_r) + 1'b1) else $error("memory pointer not incremented");
  reg_keep_mem_a: assert property (@(posedge clk) disable iff (!rst_n)
    (is_reg_r && state_r != DIS_IDLE) |=> $stable(mem_ptr_r)) else $error("register access moved memory pointer");
  holdoff_a: assert property (@(posedge clk) disable iff (!rst_n)
    (is_reg_r && state_r != DIS_IDLE) |=> hold_r != '0) else $error("switch hold-off not armed");
  mem_write_c: cover property (@(posedge clk) disable iff (!rst_n) fifo_in_valid_r);
  reg_write_c: cover property (@(posedge clk) disable iff (!rst_n) reg_wr_stb);
  read_c: cover property (@(posedge clk) disable iff (!rst_n) state_r == DIS_RDATA ##1 state_r == DIS_IDLE);
endmodule
`default_nettype wire

/* File: hw/dis_pkg.sv */
package dis_pkg;
  // ************************************************************
  // slave address fields
  // ************************************************************
  localparam logic [3:0] DIS_MEM_ID = 4'ha; // memory target type code
  localparam logic [3:0] DIS_REG_ID = 4'hd; // register target type code
  localparam logic [7:0] DIS_REG_MAX = 8'h33; // highest register address
  localparam int DIS_ID_MSB = 7; // type code top bit
  localparam int DIS_SEL_MSB = 2; // select field top bit
  localparam int DIS_RW_BIT = 0; // direction bit
  // ************************************************************
  // reset values and widths
  // ************************************************************
  localparam int DIS_MEM_AW = 15; // memory pointer width (32 KiB)
  localparam logic [14:0] DIS_MEM_PTR_RST = 15'h0000; // memory pointer after reset
  localparam logic [7:0] DIS_REG_PTR_RST = 8'h00; // register pointer after reset
  localparam int DIS_FIFO_DEPTH = 16; // write data buffer depth
  // ************************************************************
  // timing
  // ************************************************************
  localparam int DIS_CLK_MHZ = 10; // system clock rate
  localparam int DIS_SWITCH_US = 100; // register to memory switch hold-off
  localparam int DIS_SWITCH_CYC = DIS_SWITCH_US * DIS_CLK_MHZ; // hold-off in cycles
  // ************************************************************
  // protocol states
  // ************************************************************
  typedef enum logic [2:0] {
    DIS_IDLE, DIS_ADDR, DIS_PTR_HI, DIS_PTR_LO, DIS_WDATA, DIS_RDATA
  } dis_state_type;
endpackage

/* File: test/dis_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// two-wire bus master model, paced by the system clock
// ************************************************************
module dis_i2c_master (
  input wire logic clk, // system clock, paces the bus
  input wire logic sda_line, // resolved data line level
  output logic scl, // bus clock, stands high outside frames
  output logic sda_rel // high releases data to the pull-up
);
  // idle bus: both lines high
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // wait whole system clock cycles, changes land on falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one bus clock of 800 ns, data set only while scl low
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    tick(4);
    scl = 1'b1;
    tick(2);
    r = sda_line;
    tick(2);
    scl = 1'b0;
  endtask
  // data falls while clock high
  task automatic start();
    sda_rel = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_rel = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  // data rises while clock high, clock then stands still
  task automatic stop();
    sda_rel = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_rel = 1'b1;
    tick(4);
  endtask
  // eight bits msb first, then release for the acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // read eight bits, not-acknowledge the final byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

/* File: test/tb_dis_i2c_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_dis_i2c_slave;
  import dis_pkg::*;
  localparam int HOLD = 200; // shortened switch hold-off
  logic clk = 1'b0, rst_n = 1'b0, trip = 1'b0;
  logic sel_lo, sel_hi;
  logic mem_wr_ready, stall = 1'b0, ack;
  logic scl, sda_rel, sda_o, sda_oe_n, mem_wr_valid, reg_wr_stb, busy;
  logic [DIS_MEM_AW-1:0] mem_wr_addr, mem_rd_addr, p;
  logic [7:0] mem_wr_data, reg_addr, reg_wr_data, d, b0, b1;
  logic [7:0] mem [0:32767]; // memory array model
  logic [7:0] regs [0:255]; // register space model
  logic [7:0] dq [0:19]; // bytes offered during the stall
  int fails = 0, samples_checked = 0, wr_cnt = 0, cyc = 0, n, w0;
  wire sda_line = sda_rel & (sda_oe_n | sda_o); // pull-up wired-and
  always #50 clk = ~clk;
  dis_i2c_master m_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  dis_i2c_slave #(.SWITCH_CYC(HOLD), .FIFO_DEPTH(DIS_FIFO_DEPTH)) dut_u (
    .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .select_pin_low(sel_lo), .select_pin_high(sel_hi), .supply_trip_threshold(trip),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem[mem_rd_addr]),
    .reg_wr_stb(reg_wr_stb), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(regs[reg_addr]), .busy(busy));
  // memory and register sinks
  always @(posedge clk) begin
    if (mem_wr_valid === 1'b1 && mem_wr_ready) begin
      mem[mem_wr_addr] <= mem_wr_data;
      wr_cnt++;
    end
    if (reg_wr_stb === 1'b1) begin
      regs[reg_addr] <= reg_wr_data;
    end
  end
  // memory stalls at random, or hard while filling the buffer
  always @(negedge clk) mem_wr_ready <= stall ? 1'b0 : ($urandom_range(3) != 0);
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // slave address byte for this device
  function automatic logic [7:0] sa(input logic [3:0] id, input logic rw);
    return {id, 1'b0, sel_hi, sel_lo, rw};
  endfunction
  // start, write address, two pointer bytes, all acknowledged
  task automatic load_ptr(input logic [14:0] a);
    m_u.start();
    m_u.wr_byte(sa(DIS_MEM_ID, 1'b0), ack);
    chk(ack, 1);
    m_u.wr_byte({1'b0, a[14:8]}, ack);
    chk(ack, 1);
    m_u.wr_byte(a[7:0], ack);
    chk(ack, 1);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(72));
    {sel_hi, sel_lo} = 2'($urandom);
    for (int i = 0; i < 32768; i++) mem[i] = 8'($urandom);
    for (int i = 0; i < 256; i++) regs[i] = 8'($urandom);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    m_u.tick(4);
    // wrong select, then wrong type: no acknowledge, bus ignored
    m_u.start();
    m_u.wr_byte({DIS_MEM_ID, 1'b0, ~sel_hi, sel_lo, 1'b0}, ack);
    chk(ack, 0);
    m_u.wr_byte(8'h00, ack);
    chk(ack, 0);
    m_u.start();
    m_u.wr_byte({4'h5, 1'b0, sel_hi, sel_lo, 1'b0}, ack);
    chk(ack, 0);
    m_u.stop();
    $display("test mismatch done");
    // two-byte write across the top of memory
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    load_ptr(15'h7fff);
    m_u.wr_byte(b0, ack);
    chk(ack, 1);
    m_u.wr_byte(b1, ack);
    chk(ack, 1);
    m_u.stop();
    m_u.tick(20);
    chk(mem[15'h7fff], b0);
    chk(mem[15'h0000], b1);
    // current address read continues after the wrap
    m_u.start();
    m_u.wr_byte(sa(DIS_MEM_ID, 1'b1), ack);
    chk(ack, 1);
    m_u.rd_byte(1'b0, d);
    chk(d, mem[1]);
    m_u.rd_byte(1'b1, d);
    chk(d, mem[2]);
    m_u.stop();
    $display("test wrap done");
    // selective reads at random pointers
    for (int k = 0; k < 4; k++) begin
      p = 15'($urandom);
      load_ptr(p);
      m_u.start();
      m_u.wr_byte(sa(DIS_MEM_ID, 1'b1), ack);
      m_u.rd_byte(1'b1, d);
      chk(d, mem[p]);
    end
    m_u.stop();
    $display("test random read done");
    // stop before the eighth data bit leaves memory alone
    p = 15'($urandom);
    load_ptr(p);
    w0 = wr_cnt;
    for (int i = 0; i < 4; i++) m_u.bit_io(1'b0, ack);
    m_u.stop();
    m_u.tick(20);
    chk(16'(wr_cnt), 16'(w0));
    // supply trip aborts mid-transaction
    m_u.start();
    m_u.wr_byte(sa(DIS_MEM_ID, 1'b0), ack);
    chk(ack, 1);
    chk(busy, 1);
    trip = 1'b1;
    m_u.tick(8);
    trip = 1'b0;
    m_u.tick(4);
    chk(busy, 0);
    m_u.wr_byte(8'h00, ack);
    chk(ack, 0);
    m_u.stop();
    $display("test abort done");
    // stalled memory: buffer fills until refused, then drains
    stall = 1'b1;
    load_ptr(15'h0100);
    n = 0;
    ack = 1'b1;
    for (int i = 0; i < 20 && ack; i++) begin
      dq[i] = 8'($urandom);
      m_u.wr_byte(dq[i], ack);
      if (ack) n++;
    end
    m_u.stop();
    chk(16'(n >= DIS_FIFO_DEPTH && n <= DIS_FIFO_DEPTH + 1), 1);
    stall = 1'b0;
    m_u.tick(100);
    for (int i = 0; i < n; i++) chk(mem[15'h0100 + i], dq[i]);
    $display("test buffer done");
    // register target: bad address, then write across its top
    w0 = wr_cnt;
    m_u.start();
    m_u.wr_byte(sa(DIS_REG_ID, 1'b0), ack);
    chk(ack, 1);
    m_u.wr_byte(8'h34, ack);
    chk(ack, 0);
    m_u.start();
    m_u.wr_byte(sa(DIS_REG_ID, 1'b0), ack);
    m_u.wr_byte(DIS_REG_MAX, ack);
    chk(ack, 1);
    m_u.wr_byte(b0, ack);
    m_u.wr_byte(b1, ack);
    m_u.stop();
    chk(regs[DIS_REG_MAX], b0);
    chk(regs[0], b1);
    chk(16'(wr_cnt), 16'(w0));
    // register read continues from its own pointer
    m_u.start();
    m_u.wr_byte(sa(DIS_REG_ID, 1'b1), ack);
    chk(ack, 1);
    m_u.rd_byte(1'b1, d);
    chk(d, regs[1]);
    // memory refused right after, accepted after the hold-off
    m_u.start();
    m_u.wr_byte(sa(DIS_MEM_ID, 1'b1), ack);
    chk(ack, 0);
    m_u.stop();
    m_u.tick(HOLD);
    m_u.start();
    m_u.wr_byte(sa(DIS_MEM_ID, 1'b1), ack);
    chk(ack, 1);
    m_u.rd_byte(1'b1, d);
    chk(d, mem[15'h0100 + n + 1]);
    m_u.stop();
    $display("test register done");
    report_and_stop();
  end
endmodule
`default_nettype wire
